// ---- ppm_pkg.sv ----
// Constants, field layouts and carrier types of the parallel port pin mux.
package ppm_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // Register offsets, as word addresses on the register port.
  localparam logic [15:0] OFF_OUTPUT_SLEW_SELECT = 16'h1C16;
  localparam logic [15:0] OFF_PULL_INHIBIT_ONE = 16'h1C17;
  localparam logic [15:0] OFF_PULL_INHIBIT_TWO = 16'h1C18;
  localparam logic [15:0] OFF_PULL_INHIBIT_THREE = 16'h1C19;
  localparam logic [15:0] OFF_EXTERNAL_BUS_SELECT = 16'h1C00;

  // Field positions.
  localparam int ROUTE_LSB = 12;
  localparam int ROUTE_W = 3;
  localparam int SLEW_EXTERNAL_MEMORY_INTERFACE_BIT = 0;
  localparam int SLEW_CLOCK_OUTPUT_PIN_BIT = 1;
  localparam int PULL3_GPIO_LSB = 2;
  localparam int PULL3_SHARED_LSB = 8;
  localparam logic [15:0] PULL3_WRITE_MASK = 16'hFFFC;

  // Reset values.
  localparam logic [15:0] RST_OUTPUT_SLEW_SELECT = 16'h0000;
  localparam logic [15:0] RST_PULL_INHIBIT = 16'h0000;
  localparam logic [2:0] RST_ROUTE = 3'h1;

  // Parallel port route field encodings.
  localparam logic [2:0] MODE_0 = 3'h0;
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_5 = 3'h5;
  localparam logic [2:0] MODE_6 = 3'h6;

  // Depth of the pin input synchroniser.
  localparam int SYNC_STAGES = 3;

  // Which function owns a group of four shared pins.
  typedef enum logic [3:0] {
    SEL_NONE = 4'h1,
    SEL_PRIMARY = 4'h2,
    SEL_GPIO = 4'h4,
    SEL_ALT = 4'h8
  } ppm_sel_e;

  // Output value and output enable of four pins, one bit per pin.
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } ppm_lane4_s;

  // Output value and output enable of six pins, one bit per pin.
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
  } ppm_lane6_s;

endpackage : ppm_pkg

// ---- ppm_sync.sv ----
// Three-stage input synchroniser that accepts a level once stages agree.
`timescale 1ns/1ps
module ppm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Asynchronous pin levels and their filtered copy.
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  // A bit only moves once the second and third stages hold the same value.
  always_comb begin
    for (int b = 0; b < WIDTH; b++) begin
      level_next[b] = (stage2_reg[b] == stage3_reg[b]) ?
                      stage3_reg[b] : level_reg[b];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      level_reg <= '0;
    end else begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg <= level_next;
    end
  end

  assign o_level = level_reg;

endmodule : ppm_sync

// ---- ppm_pin_mux.sv ----
// Parallel port pin mux with pull-inhibit and output slew registers.
// Contract
// - Each internal pull resistor except the TRST pull-down is enabled or disabled by pull-inhibit bits.
// - The TRST pull-down is always on and never controllable.
// - A slew register selects fast or slow edges on memory and clock pins.
// - Slew control reaches only memory interface and clock output pins.
// - The bus select register alone decides all pin routing here.
// - A three-bit route field selects what drives the shared pins.
// - Route mode zero is unsupported and must not be programmed.
// - First shared pin: I2S2 clock, GPIO 18, or SPI clock by mode.
// - Next three pins: I2S2, GPIO 19/20/27, or SPI chip select/data.
// - RTS pin: UART RTS, GPIO 28, or I2S3 clock by mode.
// - CTS pin: UART CTS, GPIO 29, or I2S3 frame sync by mode.
// - UART receive pin: UART receive, GPIO 30, or I2S3 receive.
// - UART transmit pin: UART transmit, GPIO 31, or I2S3 transmit.
// - Each shared pin's pull-down has its own bit in pull-inhibit three.
`timescale 1ns/1ps
module ppm_pin_mux (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Register port.
  input wire logic [ppm_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ppm_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [ppm_pkg::DATA_W-1:0] o_rd_data,
  // Peripheral drive towards the shared pins.
  input wire ppm_pkg::ppm_lane4_s i_i2s2,
  input wire ppm_pkg::ppm_lane4_s i_gpio_lo,
  input wire ppm_pkg::ppm_lane4_s i_spi_shared,
  input wire ppm_pkg::ppm_lane4_s i_uart,
  input wire ppm_pkg::ppm_lane4_s i_gpio_hi,
  input wire ppm_pkg::ppm_lane4_s i_i2s3,
  // Peripheral drive towards the dedicated pins.
  input wire ppm_pkg::ppm_lane6_s i_spi_ded,
  input wire ppm_pkg::ppm_lane6_s i_gpio_ded,
  // Pin levels returned to the peripherals.
  output logic [3:0] o_i2s2_in,
  output logic [3:0] o_gpio_lo_in,
  output logic [3:0] o_spi_shared_in,
  output logic [3:0] o_uart_in,
  output logic [3:0] o_gpio_hi_in,
  output logic [3:0] o_i2s3_in,
  output logic o_spi_rx_in,
  output logic [5:0] o_gpio_ded_in,
  // Shared pins.
  input wire logic [7:0] i_shared_pad,
  output logic [7:0] o_shared_pad,
  output logic [7:0] o_shared_pad_oe,
  // Dedicated SPI pins and dedicated GPIO pins.
  input wire logic i_spi_rx_pad,
  output logic [5:0] o_spi_ded_pad,
  output logic [5:0] o_spi_ded_pad_oe,
  input wire logic [5:0] i_gpio_ded_pad,
  output logic [5:0] o_gpio_ded_pad,
  output logic [5:0] o_gpio_ded_pad_oe,
  // Pad controls.
  output logic [7:0] o_shared_pd_en,
  output logic [5:0] o_gpio_ded_pd_en,
  output logic [15:0] o_pull_en_one,
  output logic [15:0] o_pull_en_two,
  output logic o_trst_pd_en,
  output logic o_external_memory_interface_slow,
  output logic o_clock_output_pin_slow,
  output logic [2:0] o_route_mode
);

  // Software-visible registers.
  logic [15:0] slew_reg, slew_next;
  logic [15:0] pull1_reg, pull1_next;
  logic [15:0] pull2_reg, pull2_next;
  logic [15:0] pull3_reg, pull3_next;
  logic [2:0] route_reg, route_next;
  logic [15:0] rd_data_reg, rd_data_next;

  // Routing decode.
  ppm_pkg::ppm_sel_e front_sel;
  ppm_pkg::ppm_sel_e back_sel;
  logic ded_active;
  ppm_pkg::ppm_lane4_s front_lane;
  ppm_pkg::ppm_lane4_s back_lane;
  logic [2:0] wr_route;

  // Synchronised pin levels.
  logic [14:0] pad_level;
  logic [3:0] front_in;
  logic [3:0] back_in;
  logic rx_in;
  logic [5:0] gpio_ded_in;

  // Pad and return-path flops.
  logic [7:0] shared_pad_reg, shared_pad_next;
  logic [7:0] shared_oe_reg, shared_oe_next;
  logic [5:0] spi_pad_reg, spi_pad_next;
  logic [5:0] spi_oe_reg, spi_oe_next;
  logic [5:0] gpio_pad_reg, gpio_pad_next;
  logic [5:0] gpio_oe_reg, gpio_oe_next;
  logic [23:0] perif_in_reg, perif_in_next;
  logic spi_rx_reg, spi_rx_next;
  logic [5:0] gpio_in_reg, gpio_in_next;
  logic [7:0] shared_pd_reg, shared_pd_next;
  logic [5:0] gpio_pd_reg, gpio_pd_next;
  logic [15:0] pull_en1_reg, pull_en1_next;
  logic [15:0] pull_en2_reg, pull_en2_next;
  logic trst_pd_reg, trst_pd_next;
  logic external_memory_interface_slow_reg, external_memory_interface_slow_next;
  logic clock_output_pin_slow_reg, clock_output_pin_slow_next;

  assign wr_route = i_wr_data[ppm_pkg::ROUTE_LSB +: ppm_pkg::ROUTE_W];

  // Register writes and the one-cycle read answer.
  always_comb begin
    slew_next = slew_reg;
    pull1_next = pull1_reg;
    pull2_next = pull2_reg;
    pull3_next = pull3_reg;
    route_next = route_reg;
    rd_data_next = 16'h0000;
    if (i_wr_en) begin
      unique case (i_addr)
        ppm_pkg::OFF_OUTPUT_SLEW_SELECT: slew_next = i_wr_data;
        ppm_pkg::OFF_PULL_INHIBIT_ONE: pull1_next = i_wr_data;
        ppm_pkg::OFF_PULL_INHIBIT_TWO: pull2_next = i_wr_data;
        ppm_pkg::OFF_PULL_INHIBIT_THREE: begin
          pull3_next = i_wr_data & ppm_pkg::PULL3_WRITE_MASK;
        end
        ppm_pkg::OFF_EXTERNAL_BUS_SELECT: begin
          // An unsupported all-zero route is refused and the old one kept.
          if (wr_route != ppm_pkg::MODE_0) begin
            route_next = wr_route;
          end
        end
        default: ;
      endcase
    end
    if (i_rd_en) begin
      unique case (i_addr)
        ppm_pkg::OFF_OUTPUT_SLEW_SELECT: rd_data_next = slew_reg;
        ppm_pkg::OFF_PULL_INHIBIT_ONE: rd_data_next = pull1_reg;
        ppm_pkg::OFF_PULL_INHIBIT_TWO: rd_data_next = pull2_reg;
        ppm_pkg::OFF_PULL_INHIBIT_THREE: rd_data_next = pull3_reg;
        ppm_pkg::OFF_EXTERNAL_BUS_SELECT: begin
          rd_data_next[ppm_pkg::ROUTE_LSB +: ppm_pkg::ROUTE_W] = route_reg;
        end
        default: rd_data_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      slew_reg <= ppm_pkg::RST_OUTPUT_SLEW_SELECT;
      pull1_reg <= ppm_pkg::RST_PULL_INHIBIT;
      pull2_reg <= ppm_pkg::RST_PULL_INHIBIT;
      pull3_reg <= ppm_pkg::RST_PULL_INHIBIT;
      route_reg <= ppm_pkg::RST_ROUTE;
      rd_data_reg <= 16'h0000;
    end else begin
      slew_reg <= slew_next;
      pull1_reg <= pull1_next;
      pull2_reg <= pull2_next;
      pull3_reg <= pull3_next;
      route_reg <= route_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // Route decode: every pin choice follows the bus select register.
  always_comb begin
    unique case (route_reg)
      ppm_pkg::MODE_1, ppm_pkg::MODE_4, ppm_pkg::MODE_6: begin
        front_sel = ppm_pkg::SEL_PRIMARY;
      end
      ppm_pkg::MODE_2: front_sel = ppm_pkg::SEL_GPIO;
      ppm_pkg::MODE_3, ppm_pkg::MODE_5: begin
        front_sel = ppm_pkg::SEL_ALT;
      end
      default: front_sel = ppm_pkg::SEL_NONE;
    endcase
    unique case (route_reg)
      ppm_pkg::MODE_1, ppm_pkg::MODE_4, ppm_pkg::MODE_5: begin
        back_sel = ppm_pkg::SEL_PRIMARY;
      end
      ppm_pkg::MODE_2: back_sel = ppm_pkg::SEL_GPIO;
      ppm_pkg::MODE_3, ppm_pkg::MODE_6: begin
        back_sel = ppm_pkg::SEL_ALT;
      end
      default: back_sel = ppm_pkg::SEL_NONE;
    endcase
    ded_active = (route_reg == ppm_pkg::MODE_1) ||
                 (route_reg == ppm_pkg::MODE_6);
  end

  // Lane selection for the two groups of four shared pins.
  always_comb begin
    front_lane = '0;
    back_lane = '0;
    unique case (front_sel)
      ppm_pkg::SEL_PRIMARY: front_lane = i_i2s2;
      ppm_pkg::SEL_GPIO: front_lane = i_gpio_lo;
      ppm_pkg::SEL_ALT: front_lane = i_spi_shared;
      ppm_pkg::SEL_NONE: front_lane = '0;
    endcase
    unique case (back_sel)
      ppm_pkg::SEL_PRIMARY: back_lane = i_uart;
      ppm_pkg::SEL_GPIO: back_lane = i_gpio_hi;
      ppm_pkg::SEL_ALT: back_lane = i_i2s3;
      ppm_pkg::SEL_NONE: back_lane = '0;
    endcase
  end

  // Pin levels cross into the clock domain before anything reads them.
  ppm_sync #(
    .WIDTH(15)
  ) u_pad_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_async({i_gpio_ded_pad, i_spi_rx_pad, i_shared_pad}),
    .o_level(pad_level)
  );

  assign front_in = pad_level[3:0];
  assign back_in = pad_level[7:4];
  assign rx_in = pad_level[8];
  assign gpio_ded_in = pad_level[14:9];

  // Next pad drive, return paths and pad controls.
  always_comb begin
    shared_pad_next = {back_lane.out, front_lane.out};
    shared_oe_next = {back_lane.oe, front_lane.oe};
    perif_in_next = 24'h000000;
    unique case (front_sel)
      ppm_pkg::SEL_PRIMARY: perif_in_next[3:0] = front_in;
      ppm_pkg::SEL_GPIO: perif_in_next[7:4] = front_in;
      ppm_pkg::SEL_ALT: perif_in_next[11:8] = front_in;
      ppm_pkg::SEL_NONE: perif_in_next[3:0] = 4'h0;
    endcase
    unique case (back_sel)
      ppm_pkg::SEL_PRIMARY: perif_in_next[15:12] = back_in;
      ppm_pkg::SEL_GPIO: perif_in_next[19:16] = back_in;
      ppm_pkg::SEL_ALT: perif_in_next[23:20] = back_in;
      ppm_pkg::SEL_NONE: perif_in_next[15:12] = 4'h0;
    endcase
    spi_pad_next = ded_active ? i_spi_ded.out : 6'h00;
    spi_oe_next = ded_active ? i_spi_ded.oe : 6'h00;
    gpio_pad_next = ded_active ? i_gpio_ded.out : 6'h00;
    gpio_oe_next = ded_active ? i_gpio_ded.oe : 6'h00;
    spi_rx_next = ded_active ? rx_in : 1'b0;
    gpio_in_next = ded_active ? gpio_ded_in : 6'h00;
    // A set inhibit bit turns the matching pull resistor off.
    shared_pd_next = ~pull3_reg[ppm_pkg::PULL3_SHARED_LSB +: 8];
    gpio_pd_next = ~pull3_reg[ppm_pkg::PULL3_GPIO_LSB +: 6];
    pull_en1_next = ~pull1_reg;
    pull_en2_next = ~pull2_reg;
    trst_pd_next = 1'b1;
    external_memory_interface_slow_next = slew_reg[ppm_pkg::SLEW_EXTERNAL_MEMORY_INTERFACE_BIT];
    clock_output_pin_slow_next = slew_reg[ppm_pkg::SLEW_CLOCK_OUTPUT_PIN_BIT];
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      shared_pad_reg <= 8'h00;
      shared_oe_reg <= 8'h00;
      spi_pad_reg <= 6'h00;
      spi_oe_reg <= 6'h00;
      gpio_pad_reg <= 6'h00;
      gpio_oe_reg <= 6'h00;
      perif_in_reg <= 24'h000000;
      spi_rx_reg <= 1'b0;
      gpio_in_reg <= 6'h00;
      shared_pd_reg <= 8'hFF;
      gpio_pd_reg <= 6'h3F;
      pull_en1_reg <= 16'hFFFF;
      pull_en2_reg <= 16'hFFFF;
      trst_pd_reg <= 1'b1;
      external_memory_interface_slow_reg <= 1'b0;
      clock_output_pin_slow_reg <= 1'b0;
    end else begin
      shared_pad_reg <= shared_pad_next;
      shared_oe_reg <= shared_oe_next;
      spi_pad_reg <= spi_pad_next;
      spi_oe_reg <= spi_oe_next;
      gpio_pad_reg <= gpio_pad_next;
      gpio_oe_reg <= gpio_oe_next;
      perif_in_reg <= perif_in_next;
      spi_rx_reg <= spi_rx_next;
      gpio_in_reg <= gpio_in_next;
      shared_pd_reg <= shared_pd_next;
      gpio_pd_reg <= gpio_pd_next;
      pull_en1_reg <= pull_en1_next;
      pull_en2_reg <= pull_en2_next;
      trst_pd_reg <= trst_pd_next;
      external_memory_interface_slow_reg <= external_memory_interface_slow_next;
      clock_output_pin_slow_reg <= clock_output_pin_slow_next;
    end
  end

  assign o_rd_data = rd_data_reg;
  assign o_i2s2_in = perif_in_reg[3:0];
  assign o_gpio_lo_in = perif_in_reg[7:4];
  assign o_spi_shared_in = perif_in_reg[11:8];
  assign o_uart_in = perif_in_reg[15:12];
  assign o_gpio_hi_in = perif_in_reg[19:16];
  assign o_i2s3_in = perif_in_reg[23:20];
  assign o_spi_rx_in = spi_rx_reg;
  assign o_gpio_ded_in = gpio_in_reg;
  assign o_shared_pad = shared_pad_reg;
  assign o_shared_pad_oe = shared_oe_reg;
  assign o_spi_ded_pad = spi_pad_reg;
  assign o_spi_ded_pad_oe = spi_oe_reg;
  assign o_gpio_ded_pad = gpio_pad_reg;
  assign o_gpio_ded_pad_oe = gpio_oe_reg;
  assign o_shared_pd_en = shared_pd_reg;
  assign o_gpio_ded_pd_en = gpio_pd_reg;
  assign o_pull_en_one = pull_en1_reg;
  assign o_pull_en_two = pull_en2_reg;
  assign o_trst_pd_en = trst_pd_reg;
  assign o_external_memory_interface_slow = external_memory_interface_slow_reg;
  assign o_clock_output_pin_slow = clock_output_pin_slow_reg;
  assign o_route_mode = route_reg;

endmodule : ppm_pin_mux

// ---- ppm_pin_mux_assertions.sv ----
// Concurrent checks on the ports of the parallel port pin mux.
`timescale 1ns/1ps
module ppm_pin_mux_chk (
  // Clock, reset and register port.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_wr_en,
  // Peripheral drive.
  input wire ppm_pkg::ppm_lane4_s i_i2s2,
  input wire ppm_pkg::ppm_lane4_s i_uart,
  input wire ppm_pkg::ppm_lane6_s i_spi_ded,
  // Pins and pad controls.
  input wire logic [7:0] o_shared_pad,
  input wire logic [7:0] o_shared_pad_oe,
  input wire logic [5:0] o_spi_ded_pad,
  input wire logic [5:0] o_gpio_ded_pad_oe,
  input wire logic [7:0] o_shared_pd_en,
  input wire logic [5:0] o_gpio_ded_pd_en,
  input wire logic [15:0] o_pull_en_one,
  input wire logic o_trst_pd_en,
  input wire logic o_external_memory_interface_slow,
  input wire logic o_clock_output_pin_slow,
  input wire logic [2:0] o_route_mode
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence wr_at(a);
    i_wr_en && i_addr == a;
  endsequence

  // The route has been in force long enough for the pads to follow it.
  sequence route_steady;
    $stable(o_route_mode) [*3];
  endsequence

  trst_on_a: assert property (o_trst_pd_en)
    else $error("trst pull-down not enabled");
  pull_one_a: assert property (wr_at(ppm_pkg::OFF_PULL_INHIBIT_ONE)
    |-> ##2 o_pull_en_one == ~$past(i_wr_data, 2))
    else $error("pull enable one wrong after write");
  pull_three_a: assert property (wr_at(ppm_pkg::OFF_PULL_INHIBIT_THREE)
    |-> ##2 {o_shared_pd_en, o_gpio_ded_pd_en} == ~$past(i_wr_data[15:2], 2))
    else $error("pin pull-down enables wrong after write");
  slew_set_a: assert property (wr_at(ppm_pkg::OFF_OUTPUT_SLEW_SELECT)
    |-> ##2 {o_clock_output_pin_slow, o_external_memory_interface_slow} == $past(i_wr_data[1:0], 2))
    else $error("slew outputs wrong after write");
  slew_only_a: assert property ($changed({o_clock_output_pin_slow, o_external_memory_interface_slow})
    |-> $past(i_wr_en && i_addr == ppm_pkg::OFF_OUTPUT_SLEW_SELECT, 2))
    else $error("slew changed without slew write");
  route_set_a: assert property ((wr_at(ppm_pkg::OFF_EXTERNAL_BUS_SELECT)
    ##0 i_wr_data[14:12] != 3'h0)
    |-> ##2 o_route_mode == $past(i_wr_data[14:12], 2))
    else $error("route not taken from write");
  route_zero_a: assert property ((wr_at(ppm_pkg::OFF_EXTERNAL_BUS_SELECT)
    ##0 i_wr_data[14:12] == 3'h0)
    |-> ##2 o_route_mode == $past(o_route_mode, 2))
    else $error("route zero accepted");
  low_pins_a: assert property (route_steady
    ##0 (o_route_mode inside {3'h1, 3'h4, 3'h6})
    |-> {o_shared_pad[3:0], o_shared_pad_oe[3:0]} == $past(i_i2s2))
    else $error("first four pins not from i2s2");
  high_pins_a: assert property (route_steady
    ##0 (o_route_mode inside {3'h1, 3'h4, 3'h5})
    |-> {o_shared_pad[7:4], o_shared_pad_oe[7:4]} == $past(i_uart))
    else $error("uart pins not from uart");
  ded_spi_a: assert property (route_steady
    ##0 (o_route_mode inside {3'h1, 3'h6})
    |-> o_spi_ded_pad == $past(i_spi_ded.out))
    else $error("dedicated spi pins not driven");
  reserved_idle_a: assert property (route_steady ##0 o_route_mode == 3'h7
    |-> o_shared_pad_oe == 8'h00 && o_gpio_ded_pad_oe == 6'h00)
    else $error("pins driven in reserved route");
endmodule : ppm_pin_mux_chk

bind ppm_pin_mux ppm_pin_mux_chk chk_u (
  .i_sys_clk, .i_reset, .i_addr, .i_wr_data, .i_wr_en, .i_i2s2, .i_uart,
  .i_spi_ded, .o_shared_pad, .o_shared_pad_oe, .o_spi_ded_pad,
  .o_gpio_ded_pad_oe, .o_shared_pd_en, .o_gpio_ded_pd_en, .o_pull_en_one,
  .o_trst_pd_en, .o_external_memory_interface_slow, .o_clock_output_pin_slow, .o_route_mode
);

// ---- ppm_board_devices.sv ----
// Board devices wired to the shared, SPI and GPIO pins of the pin mux.
`timescale 1ns/1ps
module ppm_board_devices (
  // Levels the board devices drive.
  input wire logic [7:0] i_dev_level,
  input wire logic i_dev_rx,
  input wire logic [5:0] i_dev_gpio,
  // Mux drive and resulting pin levels.
  input wire logic [7:0] i_pad,
  input wire logic [7:0] i_pad_oe,
  input wire logic [5:0] i_gpio_pad,
  input wire logic [5:0] i_gpio_pad_oe,
  output logic [7:0] o_pad,
  output logic [5:0] o_gpio_pad,
  output logic o_rx_pad
);
  // External drivers hold every pin the mux releases, so pulls are idle.
  assign o_pad = (i_pad & i_pad_oe) | (i_dev_level & ~i_pad_oe);
  assign o_gpio_pad = (i_gpio_pad & i_gpio_pad_oe)
    | (i_dev_gpio & ~i_gpio_pad_oe);
  assign o_rx_pad = i_dev_rx;
endmodule : ppm_board_devices

// ---- ppm_pin_mux_tb_top.sv ----
// Self-checking testbench of the parallel port pin mux.
`timescale 1ns/1ps
module ppm_pin_mux_tb_top;
  localparam logic [15:0] BUS = ppm_pkg::OFF_EXTERNAL_BUS_SELECT;
  localparam logic [15:0] REGS [4] = '{ppm_pkg::OFF_OUTPUT_SLEW_SELECT,
    ppm_pkg::OFF_PULL_INHIBIT_ONE, ppm_pkg::OFF_PULL_INHIBIT_TWO,
    ppm_pkg::OFF_PULL_INHIBIT_THREE};
  logic i_sys_clk, i_reset, i_wr_en, i_rd_en, dev_rx;
  logic [15:0] i_addr, i_wr_data, o_rd_data, o_pull_en_one, o_pull_en_two;
  ppm_pkg::ppm_lane4_s lanes [8];
  ppm_pkg::ppm_lane6_s spi_ded, gpio_ded;
  logic [3:0] o_i2s2_in, o_gpio_lo_in, o_spi_shared_in, o_uart_in;
  logic [3:0] o_gpio_hi_in, o_i2s3_in;
  logic o_spi_rx_in, i_spi_rx_pad, o_trst_pd_en, o_external_memory_interface_slow, o_clock_output_pin_slow;
  logic [5:0] o_gpio_ded_in, o_spi_ded_pad, o_spi_ded_pad_oe, i_gpio_ded_pad;
  logic [5:0] o_gpio_ded_pad, o_gpio_ded_pad_oe, o_gpio_ded_pd_en, dev_gpio;
  logic [7:0] i_shared_pad, o_shared_pad, o_shared_pad_oe, o_shared_pd_en;
  logic [7:0] dev_level;
  logic [2:0] o_route_mode;
  int error_cnt;
  int checks_done;

  ppm_pin_mux dut_u (
    .i_sys_clk, .i_reset, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data,
    .i_i2s2(lanes[0]), .i_gpio_lo(lanes[1]), .i_spi_shared(lanes[2]),
    .i_uart(lanes[3]), .i_gpio_hi(lanes[4]), .i_i2s3(lanes[5]),
    .i_spi_ded(spi_ded), .i_gpio_ded(gpio_ded),
    .o_i2s2_in, .o_gpio_lo_in, .o_spi_shared_in, .o_uart_in, .o_gpio_hi_in,
    .o_i2s3_in, .o_spi_rx_in, .o_gpio_ded_in, .i_shared_pad, .o_shared_pad,
    .o_shared_pad_oe, .i_spi_rx_pad, .o_spi_ded_pad, .o_spi_ded_pad_oe,
    .i_gpio_ded_pad, .o_gpio_ded_pad, .o_gpio_ded_pad_oe, .o_shared_pd_en,
    .o_gpio_ded_pd_en, .o_pull_en_one, .o_pull_en_two, .o_trst_pd_en,
    .o_external_memory_interface_slow, .o_clock_output_pin_slow, .o_route_mode
  );

  ppm_board_devices dev_u (
    .i_dev_level(dev_level), .i_dev_rx(dev_rx), .i_dev_gpio(dev_gpio),
    .i_pad(o_shared_pad), .i_pad_oe(o_shared_pad_oe),
    .i_gpio_pad(o_gpio_ded_pad), .i_gpio_pad_oe(o_gpio_ded_pad_oe),
    .o_pad(i_shared_pad), .o_gpio_pad(i_gpio_ded_pad), .o_rx_pad(i_spi_rx_pad)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_sys_clk);
    i_wr_en <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    @(posedge i_sys_clk);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd_en <= 1'b0;
    #1;
    chk(o_rd_data, e);
  endtask : rd_chk

  // Level on a pin: the mux drive where enabled, else the board device.
  function automatic logic [3:0] lv(ppm_pkg::ppm_lane4_s l, logic [3:0] d);
    return (l.out & l.oe) | (d & ~l.oe);
  endfunction : lv

  task automatic t_reset();
    @(posedge i_sys_clk);
    i_reset <= 1'b1;
    repeat (11) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    #1;
    chk(16'(o_trst_pd_en), 16'h0001);
    chk(16'(o_route_mode), 16'h0001);
    chk(o_pull_en_one & o_pull_en_two, 16'hFFFF);
    for (int i = 0; i < 4; i++) begin
      rd_chk(REGS[i], 16'h0000);
    end
    rd_chk(BUS, 16'h1000);
  endtask : t_reset

  task automatic t_regs();
    logic [15:0] v;
    for (int k = 0; k < 2; k++) begin
      v = (k == 0) ? 16'hA5C3 : 16'h5A3C;
      for (int i = 0; i < 4; i++) begin
        wr(REGS[i], v);
        rd_chk(REGS[i], (i == 3) ? (v & 16'hFFFC) : v);
      end
      wr(16'h1C1A, 16'hFFFF);
      rd_chk(16'h1C1A, 16'h0000);
      rd_chk(REGS[1], v);
      repeat (2) @(posedge i_sys_clk);
      #1;
      chk(o_pull_en_one, ~v);
      chk(o_pull_en_two, ~v);
      chk(16'({o_shared_pd_en, o_gpio_ded_pd_en}), {2'b00, ~v[15:2]});
      chk(16'({o_clock_output_pin_slow, o_external_memory_interface_slow}), 16'(v[1:0]));
    end
  endtask : t_regs

  task automatic t_routes();
    logic [2:0] lo, hi;
    logic [3:0] ein [8];
    logic ded;
    logic [5:0] gl;
    wr(REGS[3], 16'hFFFC);
    for (int m = 1; m < 8; m++) begin
      @(posedge i_sys_clk);
      for (int g = 0; g < 6; g++) begin
        lanes[g] <= lanes[g] + 8'h13;
      end
      dev_level <= dev_level + 8'h35;
      dev_gpio <= dev_gpio + 6'h0B;
      dev_rx <= ~dev_rx;
      spi_ded <= spi_ded + 12'h2C7;
      gpio_ded <= gpio_ded + 12'h1D3;
      wr(BUS, {1'b0, 3'(m), 12'h000});
      rd_chk(BUS, {1'b0, 3'(m), 12'h000});
      repeat (8) @(posedge i_sys_clk);
      #1;
      lo = (m inside {1, 4, 6}) ? 3'h0 : (m == 2) ? 3'h1
        : (m inside {3, 5}) ? 3'h2 : 3'h7;
      hi = (m inside {1, 4, 5}) ? 3'h3 : (m == 2) ? 3'h4
        : (m inside {3, 6}) ? 3'h5 : 3'h7;
      ded = (m == 1) || (m == 6);
      for (int g = 0; g < 8; g++) begin
        ein[g] = 4'h0;
      end
      ein[lo] = lv(lanes[lo], dev_level[3:0]);
      ein[hi] = lv(lanes[hi], dev_level[7:4]);
      gl = (gpio_ded.out & gpio_ded.oe) | (dev_gpio & ~gpio_ded.oe);
      chk({o_shared_pad_oe, o_shared_pad}, {lanes[hi].oe, lanes[lo].oe,
        lanes[hi].out, lanes[lo].out});
      chk({o_i2s2_in, o_gpio_lo_in, o_spi_shared_in, o_uart_in},
        {ein[0], ein[1], ein[2], ein[3]});
      chk(16'({o_gpio_hi_in, o_i2s3_in}), 16'({ein[4], ein[5]}));
      chk(16'({o_spi_ded_pad, o_spi_ded_pad_oe}),
        ded ? 16'(spi_ded) : 16'h0000);
      chk(16'({o_gpio_ded_pad, o_gpio_ded_pad_oe, o_spi_rx_in}),
        ded ? 16'({gpio_ded, dev_rx}) : 16'h0000);
      chk(16'(o_gpio_ded_in), ded ? 16'(gl) : 16'h0000);
    end
    wr(BUS, 16'h0000);
    rd_chk(BUS, 16'h7000);
  endtask : t_routes

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #(2000 * 100);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    error_cnt = 0;
    checks_done = 0;
    i_reset = 1'b1;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    i_addr = 16'h0000;
    i_wr_data = 16'h0000;
    dev_level = 8'hC6;
    dev_gpio = 6'h2B;
    dev_rx = 1'b1;
    spi_ded = 12'h5A3;
    gpio_ded = 12'hA5C;
    for (int g = 0; g < 8; g++) begin
      lanes[g] = (g < 6) ? 8'(8'h1E + g * 8'h25) : 8'h00;
    end
    t_reset();
    t_regs();
    t_routes();
    t_reset();
    give_verdict();
  end
endmodule : ppm_pin_mux_tb_top
